// *** pkg/zsov_defines.vh ***
`ifndef ZSOV_DEFINES_VH
`define ZSOV_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define ZSOV_OFF_CTRL 12'h000
`define ZSOV_OFF_STATUS 12'h004
`define ZSOV_OFF_CNT_CLR 12'h008
`define ZSOV_OFF_VOLT 12'h00c
`define ZSOV_OFF_CNT_BASE 12'h010
`define ZSOV_OFF_PICKUP_BASE 12'h040
`define ZSOV_OFF_DELAY_BASE 12'h060
`define ZSOV_OFF_LOG_BASE 12'h080

// ****************************************
// field positions
// ****************************************
`define ZSOV_CTRL_FORCE 0
`define ZSOV_CTRL_GRP_LO 4
`define ZSOV_CTRL_GRP_HI 6
`define ZSOV_CTRL_SRC_LO 8
`define ZSOV_CTRL_SRC_HI 10
`define ZSOV_CTRL_MODE 16
`define ZSOV_ST_BLOCKED 0
`define ZSOV_ST_START 1
`define ZSOV_ST_TRIP 2
`define ZSOV_ST_STRIDE 4
`define ZSOV_ST_GRP_LO 8

// ****************************************
// group select sources
// ****************************************
`define ZSOV_SRC_NONE 3'h0
`define ZSOV_SRC_PHYS 3'h1
`define ZSOV_SRC_SOFT_IN 3'h2
`define ZSOV_SRC_INDIC 3'h3
`define ZSOV_SRC_SOFT_OUT 3'h4
`define ZSOV_SRC_FKEY 3'h5

// ****************************************
// reset values and trip percent
// ****************************************
`define ZSOV_RST_PICKUP 16'h03e8
`define ZSOV_RST_DELAY 20'h003e8
`define ZSOV_PCT_TRIP 7'h64

// ****************************************
// timing
// ****************************************
`define ZSOV_CLK_HZ 64'd10000000
`define ZSOV_FORCE_TIMEOUT_S 64'd300

`endif

// *** rtl/zsov_stage.v ***
`timescale 1ns/1ps
`default_nettype none
`include "zsov_defines.vh"

module zsov_stage (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // timing and measurement
    input wire tick_i,
    input wire [15:0] volt_i,
    input wire [15:0] pickup_i,
    input wire [19:0] delay_i,
    input wire block_i,
    // counter clears
    input wire clr_start_i,
    input wire clr_trip_i,
    // state
    output reg start_o,
    output reg trip_o,
    output reg [15:0] start_cnt_o,
    output reg [15:0] trip_cnt_o,
    // fault record
    output reg rec_o,
    output reg [15:0] rec_volt_o,
    output reg [6:0] rec_pct_o
);

reg [19:0] elapsed_reg;
reg [19:0] acc_reg;
reg [6:0] pct_reg;
reg [15:0] maxv_reg;
wire above;
wire [19:0] elapsed_next;
wire [20:0] acc_sum;

assign above = (volt_i > pickup_i) && !block_i;
assign elapsed_next = elapsed_reg + 20'h00001;
assign acc_sum = {1'b0, acc_reg} + 21'h000064;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        start_o <= 1'b0;
        trip_o <= 1'b0;
        elapsed_reg <= 20'h00000;
        acc_reg <= 20'h00000;
        pct_reg <= 7'h00;
        maxv_reg <= 16'h0000;
        rec_o <= 1'b0;
        rec_volt_o <= 16'h0000;
        rec_pct_o <= 7'h00;
    end else begin
        rec_o <= 1'b0;
        if (!above) begin
            start_o <= 1'b0;
            trip_o <= 1'b0;
            elapsed_reg <= 20'h00000;
            acc_reg <= 20'h00000;
            pct_reg <= 7'h00;
            maxv_reg <= 16'h0000;
            if (start_o) begin
                rec_o <= 1'b1;
                rec_volt_o <= maxv_reg;
                rec_pct_o <= pct_reg;
            end
        end else begin
            start_o <= 1'b1;
            if (volt_i > maxv_reg) begin
                maxv_reg <= volt_i;
            end
            if (tick_i && !trip_o) begin
                elapsed_reg <= elapsed_next;
                if (elapsed_next >= delay_i) begin
                    trip_o <= 1'b1;
                    pct_reg <= `ZSOV_PCT_TRIP;
                end else if (acc_sum >= {1'b0, delay_i}) begin
                    // elapsed percent, one step per delay_i/100 ticks, at most one per tick
                    acc_reg <= acc_sum[19:0] - delay_i;
                    if (pct_reg < 7'h63) begin
                        pct_reg <= pct_reg + 7'h01;
                    end
                end else begin
                    acc_reg <= acc_sum[19:0];
                end
            end
        end
    end
end

// event counters, a clear in the cycle of an event leaves a count of 1
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        start_cnt_o <= 16'h0000;
        trip_cnt_o <= 16'h0000;
    end else begin
        if (above && !start_o) begin
            start_cnt_o <= clr_start_i ? 16'h0001 : start_cnt_o + 16'h0001;
        end else if (clr_start_i) begin
            start_cnt_o <= 16'h0000;
        end
        if (above && tick_i && !trip_o && elapsed_next >= delay_i) begin
            trip_cnt_o <= clr_trip_i ? 16'h0001 : trip_cnt_o + 16'h0001;
        end else if (clr_trip_i) begin
            trip_cnt_o <= 16'h0000;
        end
    end
end

endmodule // zsov_stage
`default_nettype wire

// *** rtl/zsov_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "zsov_defines.vh"

module zsov_top #(
    parameter [63:0] FORCE_CYCLES = `ZSOV_FORCE_TIMEOUT_S * `ZSOV_CLK_HZ
) (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // measurement front end
    input wire [15:0] residual_meas_i,
    input wire [15:0] residual_sum_i,
    input wire tick_i,
    input wire [31:0] date_i,
    input wire [31:0] time_ms_i,
    // control inputs
    input wire pw_ok_i,
    input wire [1:0] block_i,
    input wire [1:0] physical_input_n_i,
    input wire [1:0] soft_input_n_i,
    input wire [1:0] indicator_signal_n_i,
    input wire [1:0] soft_output_n_i,
    input wire [1:0] function_key_n_i,
    // stage outputs
    output reg [1:0] start_o,
    output reg [1:0] trip_o
);

// ****************************************
// registers
// ****************************************
reg force_reg;
reg [31:0] force_cnt_reg;
reg [1:0] active_group_reg;
reg [2:0] group_select_source_reg;
reg mode_reg;
reg [1:0] forced_start_reg;
reg [1:0] forced_trip_reg;
reg [15:0] residual_voltage_value_reg;
reg [15:0] pickup_reg [0:7];
reg [19:0] delay_reg [0:7];
reg [31:0] log_date_reg [0:7];
reg [31:0] log_time_reg [0:7];
reg [15:0] log_volt_reg [0:7];
reg [11:0] log_info_reg [0:7];
reg [2:0] log_ptr_reg;
reg [31:0] rdata;
reg rerr;
reg [1:0] eff_group;

wire wr_en;
wire access;
wire [1:0] st_start;
wire [1:0] st_trip;
wire [31:0] st_start_cnt;
wire [31:0] st_trip_cnt;
wire [1:0] st_rec;
wire [31:0] st_rec_volt;
wire [13:0] st_rec_pct;
wire [3:0] cnt_clr;
wire [2:0] log_ptr1;
wire [2:0] log_rd_idx;

assign access = psel_i && penable_i;
// write lands on the edge that sees pready high
assign wr_en = access && pready_o && pwrite_i && !pslverr_o;
assign cnt_clr = (wr_en && paddr_i == `ZSOV_OFF_CNT_CLR) ?
    pwdata_i[3:0] : 4'h0;

// ****************************************
// apb handshake
// ****************************************
// one wait state keeps pready and prdata registered
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o <= 32'h00000000;
    end else begin
        pready_o <= access && !pready_o;
        if (access && !pready_o) begin
            prdata_o <= pwrite_i ? 32'h00000000 : rdata;
            pslverr_o <= rerr;
        end else begin
            pslverr_o <= 1'b0;
        end
    end
end

// ****************************************
// group selection
// ****************************************
always @* begin
    case (group_select_source_reg)
        `ZSOV_SRC_NONE: eff_group = active_group_reg;
        `ZSOV_SRC_PHYS: eff_group = physical_input_n_i;
        `ZSOV_SRC_SOFT_IN: eff_group = soft_input_n_i;
        `ZSOV_SRC_INDIC: eff_group = indicator_signal_n_i;
        `ZSOV_SRC_SOFT_OUT: eff_group = soft_output_n_i;
        `ZSOV_SRC_FKEY: eff_group = function_key_n_i;
        default: eff_group = active_group_reg;
    endcase
end

// ****************************************
// control, force and measurement
// ****************************************
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        force_reg <= 1'b0;
        force_cnt_reg <= 32'h00000000;
        active_group_reg <= 2'h0;
        group_select_source_reg <= `ZSOV_SRC_NONE;
        mode_reg <= 1'b0;
        forced_start_reg <= 2'h0;
        forced_trip_reg <= 2'h0;
        residual_voltage_value_reg <= 16'h0000;
    end else begin
        // front end delivers fundamental magnitude only
        residual_voltage_value_reg <= mode_reg ? residual_sum_i :
            residual_meas_i;
        // five minute self clear, a new set restarts it
        if (wr_en && paddr_i == `ZSOV_OFF_CTRL && pw_ok_i &&
            pwdata_i[`ZSOV_CTRL_FORCE]) begin
            force_reg <= 1'b1;
            force_cnt_reg <= 32'h00000000;
        end else if (wr_en && paddr_i == `ZSOV_OFF_CTRL && pw_ok_i) begin
            force_reg <= 1'b0;
        end else if (force_reg) begin
            if (force_cnt_reg >= FORCE_CYCLES[31:0] - 32'h00000001) begin
                force_reg <= 1'b0;
            end else begin
                force_cnt_reg <= force_cnt_reg + 32'h00000001;
            end
        end
        if (wr_en && paddr_i == `ZSOV_OFF_CTRL && pw_ok_i) begin
            // groups numbered 1 to 4, others ignored
            if (pwdata_i[6:4] >= 3'h1 && pwdata_i[6:4] <= 3'h4) begin
                active_group_reg <= pwdata_i[5:4] - 2'h1;
            end
            if (pwdata_i[10:8] <= `ZSOV_SRC_FKEY) begin
                group_select_source_reg <= pwdata_i[10:8];
            end
            mode_reg <= pwdata_i[`ZSOV_CTRL_MODE];
        end
        if (!force_reg) begin
            forced_start_reg <= 2'h0;
            forced_trip_reg <= 2'h0;
        end else if (wr_en && paddr_i == `ZSOV_OFF_STATUS) begin
            forced_start_reg <= {pwdata_i[5], pwdata_i[1]};
            forced_trip_reg <= {pwdata_i[6], pwdata_i[2]};
        end
    end
end

// ****************************************
// settings and stages
// ****************************************
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_set
        always @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                pickup_reg[gi] <= `ZSOV_RST_PICKUP;
                delay_reg[gi] <= `ZSOV_RST_DELAY;
            end else if (wr_en && pw_ok_i) begin
                if (paddr_i == `ZSOV_OFF_PICKUP_BASE + gi * 4) begin
                    pickup_reg[gi] <= pwdata_i[15:0];
                end
                if (paddr_i == `ZSOV_OFF_DELAY_BASE + gi * 4) begin
                    delay_reg[gi] <= pwdata_i[19:0];
                end
            end
        end
    end
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_stage
        zsov_stage u_stage (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .tick_i(tick_i),
            .volt_i(residual_voltage_value_reg),
            .pickup_i(pickup_reg[gi * 4 + eff_group]),
            .delay_i(delay_reg[gi * 4 + eff_group]),
            .block_i(block_i[gi]),
            .clr_start_i(cnt_clr[gi * 2]),
            .clr_trip_i(cnt_clr[gi * 2 + 1]),
            .start_o(st_start[gi]),
            .trip_o(st_trip[gi]),
            .start_cnt_o(st_start_cnt[gi * 16 +: 16]),
            .trip_cnt_o(st_trip_cnt[gi * 16 +: 16]),
            .rec_o(st_rec[gi]),
            .rec_volt_o(st_rec_volt[gi * 16 +: 16]),
            .rec_pct_o(st_rec_pct[gi * 7 +: 7])
        );
    end
endgenerate

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        start_o <= 2'h0;
        trip_o <= 2'h0;
    end else begin
        start_o <= st_start | forced_start_reg;
        trip_o <= st_trip | forced_trip_reg;
    end
end

// ****************************************
// fault log
// ****************************************
// both stages ending together take two slots, stage 0 first
assign log_ptr1 = st_rec[0] ? log_ptr_reg + 3'h1 : log_ptr_reg;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        log_ptr_reg <= 3'h0;
    end else begin
        log_ptr_reg <= log_ptr1 + {2'h0, st_rec[1]};
    end
end

generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_log
        always @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                log_date_reg[gi] <= 32'h00000000;
                log_time_reg[gi] <= 32'h00000000;
                log_volt_reg[gi] <= 16'h0000;
                log_info_reg[gi] <= 12'h000;
            end else if (st_rec[0] && log_ptr_reg == gi) begin
                log_date_reg[gi] <= date_i;
                log_time_reg[gi] <= time_ms_i;
                log_volt_reg[gi] <= st_rec_volt[15:0];
                log_info_reg[gi] <= {1'b0, eff_group + 2'h1 == 2'h0 ?
                    3'h4 : {1'b0, eff_group + 2'h1}, 1'b0, st_rec_pct[6:0]};
            end else if (st_rec[1] && log_ptr1 == gi) begin
                log_date_reg[gi] <= date_i;
                log_time_reg[gi] <= time_ms_i;
                log_volt_reg[gi] <= st_rec_volt[31:16];
                log_info_reg[gi] <= {1'b0, eff_group + 2'h1 == 2'h0 ?
                    3'h4 : {1'b0, eff_group + 2'h1}, 1'b1, st_rec_pct[13:7]};
            end
        end
    end
endgenerate

// ****************************************
// read mux
// ****************************************
// slot 0 of the log window is always the newest fault
assign log_rd_idx = log_ptr_reg - 3'h1 - paddr_i[6:4];

always @* begin
    rdata = 32'h00000000;
    rerr = 1'b0;
    if (paddr_i[11:8] != 4'h0 || paddr_i[1:0] != 2'h0) begin
        rerr = 1'b1;
    end else if (paddr_i[7]) begin
        case (paddr_i[3:2])
            2'h0: rdata = log_date_reg[log_rd_idx];
            2'h1: rdata = log_time_reg[log_rd_idx];
            2'h2: rdata = {16'h0000, log_volt_reg[log_rd_idx]};
            default: rdata = {20'h00000, log_info_reg[log_rd_idx]};
        endcase
    end else if (paddr_i[7:5] == 3'h2) begin
        rdata = {16'h0000, pickup_reg[paddr_i[4:2]]};
    end else if (paddr_i[7:5] == 3'h3) begin
        rdata = {12'h000, delay_reg[paddr_i[4:2]]};
    end else begin
        case (paddr_i[7:0])
            8'h00: rdata = {15'h0000, mode_reg, 5'h00,
                group_select_source_reg, 1'b0,
                {1'b0, active_group_reg} + 3'h1, 3'h0, force_reg};
            8'h04: rdata = {22'h000000, eff_group, 1'b0, trip_o[1],
                start_o[1], block_i[1], 1'b0, trip_o[0], start_o[0],
                block_i[0]};
            8'h08: rdata = 32'h00000000;
            8'h0c: rdata = {16'h0000, residual_voltage_value_reg};
            8'h10: rdata = {16'h0000, st_start_cnt[15:0]};
            8'h14: rdata = {16'h0000, st_trip_cnt[15:0]};
            8'h18: rdata = {16'h0000, st_start_cnt[31:16]};
            8'h1c: rdata = {16'h0000, st_trip_cnt[31:16]};
            default: rerr = 1'b1;
        endcase
    end
end

endmodule // zsov_top
`default_nettype wire

// *** sim/zsov_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module zsov_top_properties #(
    parameter logic [63:0] FORCE_CYCLES = 64'd50
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // front end and controls
    input wire logic [15:0] residual_meas_i,
    input wire logic [15:0] residual_sum_i,
    input wire logic tick_i,
    input wire logic [31:0] date_i,
    input wire logic [31:0] time_ms_i,
    input wire logic pw_ok_i,
    input wire logic [1:0] block_i,
    input wire logic [1:0] physical_input_n_i,
    input wire logic [1:0] soft_input_n_i,
    input wire logic [1:0] indicator_signal_n_i,
    input wire logic [1:0] soft_output_n_i,
    input wire logic [1:0] function_key_n_i,
    // stage outputs
    input wire logic [1:0] start_o,
    input wire logic [1:0] trip_o
);
    // ****************
    // stage and bus checks
    // ****************
    // forcing may legally light any output, so stop judging after it
    logic frc_seen;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            frc_seen <= 1'b0;
        else if (psel_i && pwrite_i && paddr_i == 12'h004)
            frc_seen <= 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_acc; $rose(psel_i && penable_i); endsequence
    sequence s_blk0; block_i[0] [*4]; endsequence
    sequence s_blk1; block_i[1] [*4]; endsequence
    sequence s_quiet;
        (residual_meas_i == 16'h0 && residual_sum_i == 16'h0) [*4];
    endsequence
    sequence s_rd_st;
        psel_i && penable_i && !pwrite_i && pready_o && paddr_i == 12'h004;
    endsequence
    sequence s_steady;
        start_o == $past(start_o, 1) && start_o == $past(start_o, 2)
            && start_o == $past(start_o, 3);
    endsequence
    a_rdy_wait: assert property (s_acc |-> !pready_o ##1 pready_o)
        else $error("ready not one cycle after access");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("slave error without ready");
    a_unaligned_err: assert property (
        s_acc ##0 (paddr_i[1:0] != 2'b00) |=> pslverr_o)
        else $error("unaligned access not refused");
    a_blk_quiet: assert property (s_blk0 |-> frc_seen ||
        (!start_o[0] && !trip_o[0])) else $error("blocked stage 0 active");
    a_blk1_quiet: assert property (s_blk1 |-> frc_seen ||
        (!start_o[1] && !trip_o[1])) else $error("blocked stage 1 active");
    a_zero_nostart: assert property (s_quiet |-> frc_seen ||
        start_o == 2'b00) else $error("start with zero voltage");
    a_trip_start: assert property (trip_o[0] && !frc_seen |->
        start_o[0]) else $error("trip without start");
    a_trip_tick: assert property ($rose(trip_o[0]) && !frc_seen |->
        $past(tick_i, 2)) else $error("stage 0 trip not on tick");
    a_trip1_tick: assert property ($rose(trip_o[1]) && !frc_seen |->
        $past(tick_i, 2)) else $error("stage 1 trip not on tick");
    a_start_volt: assert property ($rose(start_o[0]) && !frc_seen |->
        $past(residual_meas_i, 3) != 16'h0 ||
        $past(residual_sum_i, 3) != 16'h0) else $error("start from nothing");
    a_status_mirror: assert property (s_rd_st ##0 s_steady |->
        prdata_o[1] == start_o[0] && prdata_o[5] == start_o[1])
        else $error("status start bits differ from pins");
endmodule // zsov_top_properties
bind zsov_top zsov_top_properties #(.FORCE_CYCLES(FORCE_CYCLES)) u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .residual_meas_i(residual_meas_i),
    .residual_sum_i(residual_sum_i), .tick_i(tick_i), .date_i(date_i),
    .time_ms_i(time_ms_i), .pw_ok_i(pw_ok_i), .block_i(block_i),
    .physical_input_n_i(physical_input_n_i),
    .soft_input_n_i(soft_input_n_i),
    .indicator_signal_n_i(indicator_signal_n_i),
    .soft_output_n_i(soft_output_n_i),
    .function_key_n_i(function_key_n_i), .start_o(start_o), .trip_o(trip_o)
);
`default_nettype wire

// *** sim/zsov_front.sv ***
`timescale 1ns/1ps
`default_nettype none
module zsov_front #(
    parameter int TICK_DIV = 5
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] meas_set_i,
    input wire logic [15:0] sum_set_i,
    output logic [15:0] meas_o,
    output logic [15:0] sum_o,
    output logic tick_o,
    output logic [31:0] date_o,
    output logic [31:0] time_ms_o
);
    // ****************
    // filtered magnitudes and timer tick
    // ****************
    logic [7:0] div_reg;
    // arbitrary fixed date, the log only copies it
    assign date_o = 32'h0000_0001;
    // fundamental magnitudes in 0.01 percent, both paths
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_reg <= 8'h00;
            tick_o <= 1'b0;
            time_ms_o <= 32'h0;
            meas_o <= 16'h0;
            sum_o <= 16'h0;
        end else begin
            meas_o <= meas_set_i;
            sum_o <= sum_set_i;
            tick_o <= (div_reg == 8'(TICK_DIV - 1));
            div_reg <= (div_reg == 8'(TICK_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
            if (tick_o)
                time_ms_o <= time_ms_o + 32'h1;
        end
    end
endmodule // zsov_front
`default_nettype wire

// *** sim/zsov_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module zsov_top_tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] meas_set = 16'h0;
    logic [15:0] sum_set = 16'h0;
    logic [15:0] meas;
    logic [15:0] sum;
    logic tick;
    logic [31:0] date;
    logic [31:0] tms;
    logic pw_ok = 1'b0;
    logic [1:0] blk = 2'b00;
    logic [1:0] sel [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h3};
    logic [1:0] start;
    logic [1:0] trip;
    logic [31:0] rd;
    logic er;
    int mismatches = 0;
    int tests_run = 0;
    // voltage beside expected start, pickup at reset is 1000
    localparam logic [16:0] ROWS [6] = '{{16'd999, 1'b0}, {16'd1000, 1'b0},
        {16'd1001, 1'b1}, {16'd0, 1'b0}, {16'd2000, 1'b1}, {16'd0, 1'b0}};
    zsov_top #(.FORCE_CYCLES(64'd50)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .residual_meas_i(meas), .residual_sum_i(sum), .tick_i(tick),
        .date_i(date), .time_ms_i(tms), .pw_ok_i(pw_ok), .block_i(blk),
        .physical_input_n_i(sel[0]), .soft_input_n_i(sel[1]),
        .indicator_signal_n_i(sel[2]), .soft_output_n_i(sel[3]),
        .function_key_n_i(sel[4]), .start_o(start), .trip_o(trip));
    zsov_front u_front (
        .clk_i(clk_i), .nrst_i(nrst_i), .meas_set_i(meas_set),
        .sum_set_i(sum_set), .meas_o(meas), .sum_o(sum), .tick_o(tick),
        .date_o(date), .time_ms_o(tms));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ****************
    // bus and compare tasks
    // ****************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // pready read here is what the slave saw at this edge
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t pins got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_word(rd & m, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic end_sim;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        apb(1'b1, 12'h040, 32'h5);
        rdx(12'h040, 32'hffff, 32'h3e8);
        apb(1'b0, 12'h200, 32'h0);
        chk_pin({1'b0, er}, 2'b01);
        apb(1'b1, 12'h002, 32'h0);
        chk_pin({1'b0, er}, 2'b01);
        pw_ok <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            meas_set <= ROWS[i][16:1];
            cyc(8);
            chk_pin(start, {2{ROWS[i][0]}});
        end
        apb(1'b1, 12'h060, 32'h3);
        apb(1'b1, 12'h070, 32'h3);
        meas_set <= 16'd1500;
        cyc(8);
        chk_pin(trip, 2'b00);
        cyc(30);
        chk_pin(trip, 2'b11);
        meas_set <= 16'h0;
        cyc(8);
        chk_pin(start | trip, 2'b00);
        rdx(12'h08c, 32'h7ff, 32'h1e4);
        rdx(12'h09c, 32'h7ff, 32'h164);
        rdx(12'h088, 32'hffff, 32'h5dc);
        rdx(12'h010, 32'hffff, 32'h3);
        rdx(12'h014, 32'hffff, 32'h1);
        apb(1'b1, 12'h008, 32'h3);
        rdx(12'h010, 32'hffff, 32'h0);
        rdx(12'h018, 32'hffff, 32'h3);
        rdx(12'h01c, 32'hffff, 32'h1);
        meas_set <= 16'd1500;
        cyc(8);
        rdx(12'h004, 32'h33, 32'h22);
        blk <= 2'b01;
        cyc(6);
        chk_pin(start, 2'b10);
        rdx(12'h004, 32'h33, 32'h21);
        blk <= 2'b10;
        cyc(6);
        chk_pin(start, 2'b01);
        rdx(12'h004, 32'h33, 32'h12);
        blk <= 2'b00;
        meas_set <= 16'h0;
        cyc(8);
        apb(1'b1, 12'h050, 32'h100);
        sum_set <= 16'h200;
        cyc(8);
        chk_pin(start, 2'b00);
        apb(1'b1, 12'h000, 32'h10010);
        cyc(8);
        chk_pin(start, 2'b10);
        apb(1'b1, 12'h000, 32'h10);
        sum_set <= 16'h0;
        apb(1'b1, 12'h000, 32'h20);
        rdx(12'h004, 32'h300, 32'h100);
        apb(1'b1, 12'h000, 32'h0);
        rdx(12'h004, 32'h300, 32'h100);
        for (int s = 1; s < 6; s++) begin
            apb(1'b1, 12'h000, 32'h10 | (32'(s) << 8));
            rdx(12'h004, 32'h300, {22'h0, sel[s - 1], 8'h0});
        end
        nrst_i <= 1'b0;
        cyc(2);
        chk_pin(start | trip, 2'b00);
        nrst_i <= 1'b1;
        rdx(12'h000, 32'h1ffff, 32'h10);
        rdx(12'h040, 32'hffff, 32'h3e8);
        rdx(12'h060, 32'hfffff, 32'h3e8);
        apb(1'b1, 12'h004, 32'h2);
        cyc(3);
        chk_pin(start, 2'b00);
        apb(1'b1, 12'h000, 32'h11);
        apb(1'b1, 12'h004, 32'h2);
        cyc(3);
        chk_pin(start, 2'b01);
        cyc(60);
        chk_pin(start, 2'b00);
        rdx(12'h000, 32'h1, 32'h0);
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        end_sim;
    end
endmodule // zsov_top_tb_top
`default_nettype wire
